// ### src/pph_pkg.sv
// Package for the parallel printer handshake port: map, fields, carriers
package pph_pkg;

  // ==========================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam int unsigned PPH_ADDR_W = 4;
  localparam logic [PPH_ADDR_W-1:0] PPH_OFS_DATA = 4'h0;
  localparam logic [PPH_ADDR_W-1:0] PPH_OFS_CSR  = 4'h4;
  localparam logic [PPH_ADDR_W-1:0] PPH_OFS_PINS = 4'h8;

  // ==========================================================
  // Control/status field positions
  localparam int unsigned PPH_BIT_IBF    = 0;
  localparam int unsigned PPH_BIT_OBF    = 1;
  localparam int unsigned PPH_BIT_INPUT_STROBE_MODE   = 2;
  localparam int unsigned PPH_BIT_OUTPUT_FLAG_CONTROL   = 3;
  localparam int unsigned PPH_BIT_FM_LO  = 4;
  localparam int unsigned PPH_BIT_FM_HI  = 5;
  localparam int unsigned PPH_BIT_SM_LO  = 6;
  localparam int unsigned PPH_BIT_SM_HI  = 7;
  localparam int unsigned PPH_CTL_LO     = 2;

  // Writable mode bits come up all ones
  localparam logic [5:0] PPH_CTL_RESET = 6'h3f;

  // Flag pin modes: 0x pin follows the low mode bit itself
  localparam logic [1:0] PPH_PIN_FLAG  = 2'h2;
  localparam logic [1:0] PPH_PIN_INPUT = 2'h3;

  // AXI responses
  localparam logic [1:0] PPH_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PPH_RESP_DECERR = 2'h3;

  // ==========================================================
  // Link carriers
  typedef struct packed {
    logic [7:0] data;
    logic       input_data_strobe;
    logic       output_data_strobe;
    logic       first_in;
    logic       second_in;
    logic       busy_sense;
  } pph_link_in_type;

  typedef struct packed {
    logic [7:0] data;
    logic       data_oe;
    logic       first_out;
    logic       first_oe;
    logic       second_out;
    logic       second_oe;
  } pph_link_out_type;

  // ==========================================================
  // Whole module state
  typedef struct packed {
    logic [5:0]            ctl;
    logic                  output_buffer_full_flag;
    logic                  input_buffer_full_flag;
    logic [7:0]            out_latch;
    logic [7:0]            in_latch;
    logic                  ids_q;
    logic                  ods_q;
    logic                  aw_got;
    logic [PPH_ADDR_W-1:0] awaddr;
    logic                  w_got;
    logic [7:0]            wdata;
    logic                  wstrb0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } pph_state_type;

endpackage

// ### src/pph_port.sv
// Parallel printer handshake port with AXI4-Lite register access
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
// Summary of operation
// - The link uses eight data lines plus strobe, acknowledge and busy.
// - Transmitter may send after acknowledge rise or busy fall.
// - Output-only mode keeps drivers on; output strobe only clears output flag.
// - Transmit mode: input strobe edge sets input flag, latch unused.
// - Transmit mode: a dummy data read clears the stale input flag.
// - Transmit mode: control bit 6 drives the second flag pin (strobe).
// - Transmit mode: first flag pin follows the output flag.
// - Output flag clears on rising edge of the output data strobe.
// - Control/status holds both pin modes, flag control, strobe mode, flags.
// - Receive mode: input flag drives the second flag pin as busy.
// - Receive mode: input strobe rise latches data and sets input flag.
// - Receive mode: control bit 4 drives the first flag pin (acknowledge).
// - Transmitter waits while busy is high before sending a byte.
// - Transmitter pulses strobe low via bit 6 for two clock cycles (40 ns).
// - Transmitter waits for output flag clear or input flag set.
// - Receiver set-up does one dummy read to clear a stale input flag.
// - Receiver clears bit 4, reads the byte, then sets bit 4 again.
// - Transmitter handles all three styles; receiver uses the common one.
// - A data read clears the input flag automatically.
// - The input flag reads as bit 0 of control/status.
module pph_port
  import pph_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // AXI4-Lite write address and data
  input  wire logic [PPH_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [PPH_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Printer link
  input  wire pph_link_in_type       link_in,
  output pph_link_out_type           link_out
);

  // ==========================================================
  // Helpers
  function automatic logic known_addr(input logic [PPH_ADDR_W-1:0] a);
    known_addr = (a == PPH_OFS_DATA) || (a == PPH_OFS_CSR) || (a == PPH_OFS_PINS);
  endfunction

  // Pin value for a mode: 0x gives the low mode bit, 10 the flag
  function automatic logic flag_pin(input logic [1:0] mode, input logic flag);
    if (mode == PPH_PIN_FLAG) begin
      flag_pin = flag;
    end else if (mode == PPH_PIN_INPUT) begin
      flag_pin = 1'b0;
    end else begin
      flag_pin = mode[0];
    end
  endfunction

  // ==========================================================
  // State
  pph_state_type s_r;
  pph_state_type s_nxt;

  logic [7:0]            port_handshake_control_status;
  logic [1:0]            fmode;
  logic [1:0]            smode;
  logic                  input_strobe_mode;
  logic                  output_only;
  logic                  port_en;
  logic                  ids_rise;
  logic                  ids_fall;
  logic                  ods_rise;
  logic                  aw_hs;
  logic                  w_hs;
  logic                  ar_hs;
  logic                  wr_go;
  logic [PPH_ADDR_W-1:0] wr_addr;
  logic [7:0]            wr_data;
  logic                  wr_lane0;
  logic                  wr_data_reg;
  logic                  wr_csr_reg;
  logic                  rd_data_reg;

  assign port_handshake_control_status   = {s_r.ctl, s_r.output_buffer_full_flag, s_r.input_buffer_full_flag};
  assign fmode = port_handshake_control_status[PPH_BIT_FM_HI:PPH_BIT_FM_LO];
  assign smode = port_handshake_control_status[PPH_BIT_SM_HI:PPH_BIT_SM_LO];
  assign input_strobe_mode  = port_handshake_control_status[PPH_BIT_INPUT_STROBE_MODE];

  // Transmit set-up: first pin shows the output flag, second pin is plain
  assign output_only = (fmode == PPH_PIN_FLAG) && !smode[1];

  // Second pin as an input high disables drivers and strobes
  assign port_en = !((smode == PPH_PIN_INPUT) && link_in.second_in);

  // Pins are taken as synchronous; one delay stage finds the edges
  assign ids_rise = port_en && link_in.input_data_strobe && !s_r.ids_q;
  assign ids_fall = port_en && !link_in.input_data_strobe && s_r.ids_q;
  assign ods_rise = port_en && link_in.output_data_strobe && !s_r.ods_q;

  // ==========================================================
  // AXI4-Lite handshakes
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  // Write fires on the edge where the later of address and data lands
  assign wr_go    = (s_r.aw_got || aw_hs) && (s_r.w_got || w_hs);
  assign wr_addr  = s_r.aw_got ? s_r.awaddr : s_axi_awaddr;
  assign wr_data  = s_r.w_got ? s_r.wdata : s_axi_wdata[7:0];
  assign wr_lane0 = s_r.w_got ? s_r.wstrb0 : s_axi_wstrb[0];

  assign wr_data_reg = wr_go && wr_lane0 && (wr_addr == PPH_OFS_DATA);
  assign wr_csr_reg  = wr_go && wr_lane0 && (wr_addr == PPH_OFS_CSR);
  assign rd_data_reg = ar_hs && (s_axi_araddr == PPH_OFS_DATA);

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt       = s_r;
    s_nxt.ids_q = link_in.input_data_strobe;
    s_nxt.ods_q = link_in.output_data_strobe;

    // Input flag: a data read clears it, a strobe edge sets it.
    // The set comes last so an edge in the read cycle is kept.
    if (rd_data_reg) begin
      s_nxt.input_buffer_full_flag = 1'b0;
    end
    if (input_strobe_mode && ids_fall) begin
      s_nxt.input_buffer_full_flag = 1'b1;
    end
    if (!input_strobe_mode && ids_rise) begin
      s_nxt.in_latch = link_in.data;
      s_nxt.input_buffer_full_flag      = 1'b1;
    end

    // Output flag: acknowledge edge clears, a new byte sets
    if (ods_rise) begin
      s_nxt.output_buffer_full_flag = 1'b0;
    end
    if (wr_data_reg) begin
      s_nxt.out_latch = wr_data;
      s_nxt.output_buffer_full_flag       = 1'b1;
    end

    // Only the mode bits are writable; flags are hardware owned
    if (wr_csr_reg) begin
      s_nxt.ctl = wr_data[PPH_BIT_SM_HI:PPH_CTL_LO];
    end

    // Write channel bookkeeping
    if (aw_hs) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      s_nxt.w_got  = 1'b1;
      s_nxt.wdata  = s_axi_wdata[7:0];
      s_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = known_addr(wr_addr) ? PPH_RESP_OKAY : PPH_RESP_DECERR;
    end

    // Read channel: answer one cycle after the address is taken
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = PPH_RESP_OKAY;
      case (s_axi_araddr)
        PPH_OFS_DATA: begin
          s_nxt.rdata = {24'h000000, s_r.in_latch};
        end
        PPH_OFS_CSR: begin
          s_nxt.rdata = {24'h000000, port_handshake_control_status};
        end
        PPH_OFS_PINS: begin
          // Busy line is polled here before a byte goes out
          s_nxt.rdata = {27'h0000000, link_in.second_in, link_in.first_in,
                         link_in.output_data_strobe, link_in.input_data_strobe, link_in.busy_sense};
        end
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = PPH_RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r     <= '0;
      s_r.ctl <= PPH_CTL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Link pins
  always_comb begin
    link_out.data = s_r.out_latch;
    // Outside output-only mode drivers follow the output strobe level
    link_out.data_oe    = port_en && (output_only || !link_in.output_data_strobe);
    link_out.first_out  = flag_pin(fmode, s_r.output_buffer_full_flag);
    link_out.first_oe   = (fmode != PPH_PIN_INPUT);
    link_out.second_out = flag_pin(smode, s_r.input_buffer_full_flag);
    link_out.second_oe  = (smode != PPH_PIN_INPUT);
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ibf_edge_set_a: assert property (input_strobe_mode && ids_fall |=> s_r.input_buffer_full_flag)
    else $error("busy edge did not set input flag");

  ibf_read_clr_a: assert property (
    rd_data_reg && !ids_fall && !ids_rise |=> !s_r.input_buffer_full_flag)
    else $error("data read did not clear input flag");

  rx_latch_a: assert property (
    !input_strobe_mode && ids_rise |=> s_r.input_buffer_full_flag && s_r.in_latch == $past(link_in.data))
    else $error("receive strobe did not latch data");

  obf_ack_clr_a: assert property (ods_rise && !wr_data_reg |=> !s_r.output_buffer_full_flag)
    else $error("acknowledge edge did not clear output flag");

  obf_write_set_a: assert property (
    wr_data_reg |=> s_r.output_buffer_full_flag && s_r.out_latch == $past(wr_data))
    else $error("data write did not set output flag");

  drivers_on_a: assert property (output_only && port_en |-> link_out.data_oe)
    else $error("drivers off in output-only mode");

  strobe_pin_a: assert property (
    !smode[1] |-> link_out.second_oe && link_out.second_out == port_handshake_control_status[PPH_BIT_SM_LO])
    else $error("second pin does not follow bit 6");

  busy_pin_a: assert property (smode == PPH_PIN_FLAG |-> link_out.second_out == s_r.input_buffer_full_flag)
    else $error("second pin does not show input flag");

  ack_pin_a: assert property (
    !fmode[1] |-> link_out.first_oe && link_out.first_out == port_handshake_control_status[PPH_BIT_FM_LO])
    else $error("first pin does not follow bit 4");

  obf_pin_a: assert property (fmode == PPH_PIN_FLAG |-> link_out.first_out == s_r.output_buffer_full_flag)
    else $error("first pin does not show output flag");

  csr_read_a: assert property (
    ar_hs && s_axi_araddr == PPH_OFS_CSR
    |=> s_axi_rvalid && s_axi_rdata[PPH_BIT_IBF] == $past(s_r.input_buffer_full_flag)
        && s_axi_rdata[PPH_BIT_OBF] == $past(s_r.output_buffer_full_flag))
    else $error("control/status read shows wrong flags");

  write_resp_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("write not answered in one cycle");

  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");

  tx_byte_c: cover property (wr_data_reg ##[1:40] ods_rise);
  tx_busy_c: cover property (wr_data_reg ##[1:40] (input_strobe_mode && ids_fall));
  rx_byte_c: cover property ((!input_strobe_mode && ids_rise) ##[1:40] rd_data_reg);
  set_wins_c: cover property (rd_data_reg && input_strobe_mode && ids_fall);

endmodule

// ### verif/pph_printer_model.sv
// Printer-side partner model for the handshake port
`timescale 1ns/10ps
module pph_printer_model
  import pph_pkg::*;
(
  // Clock, reset and scenario control
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [1:0]       style,
  input  wire logic             send,
  input  wire logic [7:0]       send_d,
  // Link
  input  wire pph_link_out_type lo,
  output pph_link_in_type       li,
  output logic [7:0]            got
);
  logic [3:0] cnt;
  logic       stb_q;
  logic [7:0] last;
  logic       stb;

  // Released pins float high through pull-ups
  assign stb = lo.second_oe ? lo.second_out : 1'b1;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      stb_q <= 1'b1;
      got <= 8'h00;
      last <= 8'h00;
    end else begin
      stb_q <= stb;
      if (style != 2'h0 && stb && !stb_q) begin
        cnt <= 4'h1;
        got <= lo.data;
      end else if (style == 2'h0 && send) begin
        cnt <= 4'h1;
        last <= send_d;
      end else if (cnt != 4'h0) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      end
    end
  end

  // Style 0 sends bytes; styles 1 to 3 are the three receiver handshakes
  always_comb begin
    li.data = (style == 2'h0 && cnt != 4'h0) ? last : ~last;
    li.input_data_strobe = (style == 2'h0) ? !(cnt inside {[1:2]}) :
             (style != 2'h2 && cnt inside {[1:3]});
    li.output_data_strobe = !(style != 2'h0 && style != 2'h3 && cnt inside {[5:6]});
    li.busy_sense = style != 2'h0 && li.input_data_strobe;
    li.first_in = lo.first_oe ? lo.first_out : 1'b1;
    li.second_in = stb;
  end
endmodule

// ### verif/pph_port_bench.sv
// Self-checking bench for the parallel printer handshake port
`timescale 1ns/10ps
module pph_port_bench
  import pph_pkg::*;
;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  logic [PPH_ADDR_W-1:0] aw_a = '0;
  logic [PPH_ADDR_W-1:0] ar_a = '0;
  logic                  awv = 1'b0;
  logic                  wv = 1'b0;
  logic                  arv = 1'b0;
  // Response readies stay high so no task ever lowers and raises them in one step
  logic                  bre = 1'b1;
  logic                  rre = 1'b1;
  logic [31:0]           w_d = '0;
  logic [3:0]            w_s = 4'h1;
  logic [1:0]            style = 2'h0;
  logic                  send = 1'b0;
  logic [7:0]            send_d = 8'h00;
  logic [31:0]           seed = 32'hbbc0;
  logic                  awr, wr_y, arr, bv, rv;
  logic [1:0]            bresp, rresp;
  logic [31:0]           rdata;
  logic [7:0]            got;
  pph_link_in_type       link_in;
  pph_link_out_type      link_out;
  int                    n_errors = 0;
  int                    checks_done = 0;
  int                    cyc = 0;

  pph_port dut_u (.clk(clk), .nrst(nrst), .s_axi_awaddr(aw_a), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(wv),
    .s_axi_wready(wr_y), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar_a), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre), .link_in(link_in),
    .link_out(link_out));
  pph_printer_model prt_u (.clk(clk), .nrst(nrst), .style(style), .send(send),
    .send_d(send_d), .lo(link_out), .li(link_in), .got(got));

  always #10 clk = ~clk;

  // ==========================================================
  // Reporting and hang guard
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t reg got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t pin got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // ==========================================================
  // AXI4-Lite master; every task starts and ends just after an edge
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    aw_a <= a;
    w_d <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awr === 1'b1) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wr_y === 1'b1) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    r = bresp;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    ar_a <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic [1:0] r;
    axr(a, d, r);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    logic [31:0] v, ex;
    logic [1:0]  r;
    logic [7:0]  b;
    logic [7:0]  sent[$];
    int          n;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(PPH_OFS_CSR, v);
    chk_reg(v, 32'hfc);
    axr(4'hc, v, r);
    chk_reg({30'h0, r}, {30'h0, PPH_RESP_DECERR});
    axw(4'hc, 32'h0, r);
    chk_reg({30'h0, r}, {30'h0, PPH_RESP_DECERR});
    // Transmit to each receiver style in turn
    wr(PPH_OFS_CSR, 32'h64);
    chk_pin(link_out.second_out, 1'b1);
    for (int s = 1; s <= 3; s++) begin
      style <= s[1:0];
      do rd(PPH_OFS_PINS, v); while (v[0] !== 1'b0);
      b = rnd();
      wr(PPH_OFS_DATA, {24'h0, b});
      chk_pin(link_out.first_out, 1'b1);
      rd(PPH_OFS_DATA, v);
      rd(PPH_OFS_CSR, v);
      chk_reg(v, 32'h66);
      wr(PPH_OFS_CSR, 32'h24);
      chk_pin(link_out.second_out, 1'b0);
      wr(PPH_OFS_CSR, 32'h64);
      ex = 32'h64 | {31'h0, s != 2} | {30'h0, s == 3, 1'b0};
      n = 0;
      do begin
        rd(PPH_OFS_CSR, v);
        n++;
      end while (v !== ex && n < 40);
      chk_reg(v, ex);
      chk_reg({24'h0, got}, {24'h0, b});
      chk_pin(link_out.data_oe, 1'b1);
    end
    // Receive three bytes with acknowledge pulses
    // Rising-edge latch needs the input strobe mode bit clear
    style <= 2'h0;
    wr(PPH_OFS_CSR, 32'h98);
    rd(PPH_OFS_DATA, v);
    for (int i = 0; i < 3; i++) begin
      b = rnd();
      sent.push_back(b);
      send_d <= b;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      n = 0;
      do begin
        rd(PPH_OFS_CSR, v);
        n++;
      end while (v[0] !== 1'b1 && n < 40);
      // Output flag stays set: the last byte went to a receiver that never acknowledges
      chk_reg(v, 32'h9b);
      chk_pin(link_out.second_out, 1'b1);
      wr(PPH_OFS_CSR, 32'h88);
      chk_pin(link_out.first_out, 1'b0);
      rd(PPH_OFS_DATA, v);
      chk_reg(v, {24'h0, sent.pop_front()});
      chk_pin(link_out.second_out, 1'b0);
      wr(PPH_OFS_CSR, 32'h98);
      chk_pin(link_out.first_out, 1'b1);
    end
    stop_test();
  end
endmodule
